/* File: include/adcseq_regs.vh */
// adcseq_regs.vh: field layout, codes and reset value of the sequence control
// register used by the adc conversion sequencer.
// assumes: included by bare name from the logic files, definitions only.
`ifndef ADCSEQ_REGS_VH
`define ADCSEQ_REGS_VH

// ------------------------------------------------------------------
// adc_sequence_control fields
// ------------------------------------------------------------------
`define ADCSEQ_CTRL_W        8
`define ADCSEQ_CTRL_RESET    8'h00
`define ADCSEQ_CAL_BIT       7
`define ADCSEQ_MODE_HI       6
`define ADCSEQ_MODE_LO       5
`define ADCSEQ_CSEL_HI       4
`define ADCSEQ_CSEL_LO       3
`define ADCSEQ_SSEL_HI       2
`define ADCSEQ_SSEL_LO       0

// ------------------------------------------------------------------
// measurement mode codes
// ------------------------------------------------------------------
`define ADCSEQ_MODE_CONT     2'h0
`define ADCSEQ_MODE_SNAP     2'h1
`define ADCSEQ_MODE_SINGLE   2'h2
`define ADCSEQ_MODE_SHUT     2'h3

// ------------------------------------------------------------------
// continuous scan selection codes
// ------------------------------------------------------------------
`define ADCSEQ_CSEL_ALL      2'h0
`define ADCSEQ_CSEL_SENSE    2'h1
`define ADCSEQ_CSEL_AUX12    2'h2
`define ADCSEQ_CSEL_AUX1234  2'h3

// ------------------------------------------------------------------
// snapshot selection codes
// ------------------------------------------------------------------
`define ADCSEQ_SSEL_S1       3'h0
`define ADCSEQ_SSEL_S2       3'h1
`define ADCSEQ_SSEL_AUX1     3'h2
`define ADCSEQ_SSEL_AUX2     3'h3
`define ADCSEQ_SSEL_AUX3     3'h4
`define ADCSEQ_SSEL_AUX4     3'h5
`define ADCSEQ_SSEL_SENSE    3'h6
`define ADCSEQ_SSEL_AUX12    3'h7

// ------------------------------------------------------------------
// voltage converter channel numbers and masks (bit n = channel n)
// ------------------------------------------------------------------
`define ADCSEQ_CH_W          3
`define ADCSEQ_CH_LAST       5
`define ADCSEQ_MASK_ALL      6'h3f
`define ADCSEQ_MASK_SENSE    6'h03
`define ADCSEQ_MASK_AUX12    6'h0c
`define ADCSEQ_MASK_AUX1234  6'h3c
`define ADCSEQ_MASK_NONE     6'h00

// ------------------------------------------------------------------
// worked control values
// ------------------------------------------------------------------
`define ADCSEQ_VAL_FASTSENSE 8'h88
`define ADCSEQ_VAL_SNAPAUX12 8'h27

`endif

/* File: logic/adcseq_sequencer.v */
// adcseq_sequencer.v: conversion sequencer for two current converters and one
// multiplexed voltage converter, steered by the 8-bit sequence control register.
// assumes: one 250 MHz clock, synchronous active-high reset, a serial
// management front end that presents each completed control write as a
// one-cycle strobe, and converters that answer each start with a done pulse.

`include "adcseq_regs.vh"

module adcseq_sequencer (
   input  wire       MCLK_I,
   input  wire       SYS_RST_I,
   input  wire       CTRL_WR_I,
   input  wire [7:0] CTRL_DATA_I,
   input  wire       VCONV_DONE_I,
   input  wire       ICONV_DONE_I,
   output wire [7:0] CTRL_O,
   output wire       VCONV_START_O,
   output wire [2:0] VCONV_CHAN_O,
   output wire       VCONV_BUSY_O,
   output wire       ICONV_START_O,
   output wire       ICONV_CAL_O,
   output wire       ICONV_BUSY_O,
   output wire       POWER_UPD_O,
   output wire       POWER_AUX_O,
   output wire       SHUTDOWN_O
);

   // ------------------------------------------------------------------
   // states
   // ------------------------------------------------------------------
   localparam [1:0] ST_IDLE  = 2'h0;
   localparam [1:0] ST_START = 2'h1;
   localparam [1:0] ST_WAIT  = 2'h2;

   // ------------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------------

   // channel mask that the voltage converter walks for a control value
   function [5:0] chan_mask;
      input [7:0] c;
      begin
         case (c[`ADCSEQ_MODE_HI:`ADCSEQ_MODE_LO])
            `ADCSEQ_MODE_CONT: begin
               case (c[`ADCSEQ_CSEL_HI:`ADCSEQ_CSEL_LO])
                  `ADCSEQ_CSEL_AUX1234: chan_mask = `ADCSEQ_MASK_AUX1234;
                  `ADCSEQ_CSEL_AUX12:   chan_mask = `ADCSEQ_MASK_AUX12;
                  `ADCSEQ_CSEL_SENSE:   chan_mask = `ADCSEQ_MASK_SENSE;
                  default:              chan_mask = `ADCSEQ_MASK_ALL;
               endcase
            end
            `ADCSEQ_MODE_SNAP: begin
               case (c[`ADCSEQ_SSEL_HI:`ADCSEQ_SSEL_LO])
                  `ADCSEQ_SSEL_AUX12: chan_mask = `ADCSEQ_MASK_AUX12;
                  `ADCSEQ_SSEL_SENSE: chan_mask = `ADCSEQ_MASK_SENSE;
                  // single input: one-hot on the selected channel
                  default: chan_mask = 6'h01 << c[`ADCSEQ_SSEL_HI:`ADCSEQ_SSEL_LO];
               endcase
            end
            `ADCSEQ_MODE_SINGLE: chan_mask = `ADCSEQ_MASK_ALL;
            default:             chan_mask = `ADCSEQ_MASK_NONE;
         endcase
      end
   endfunction

   // lowest channel in the mask at or above start, msb flags a hit
   function [3:0] first_chan;
      input [5:0] m;
      input [2:0] start;
      integer i;
      begin
         first_chan = 4'h0;
         for (i = `ADCSEQ_CH_LAST; i >= 0; i = i - 1) begin
            if (m[i] && (i >= start)) begin
               first_chan = {1'b1, i[2:0]};
            end
         end
      end
   endfunction

   // whether a finished current conversion refreshes the rail powers
   function power_en;
      input [7:0] c;
      begin
         case (c[`ADCSEQ_MODE_HI:`ADCSEQ_MODE_LO])
            `ADCSEQ_MODE_CONT:   power_en = 1'b1;
            `ADCSEQ_MODE_SINGLE: power_en = 1'b1;
            // only the two pair codes carry power in a snapshot
            `ADCSEQ_MODE_SNAP:   power_en = c[`ADCSEQ_SSEL_HI] & c[`ADCSEQ_SSEL_HI-1];
            default:             power_en = 1'b0;
         endcase
      end
   endfunction

   // whether the power operands are aux 1/2 rather than the sense pins
   function power_aux;
      input [7:0] c;
      begin
         case (c[`ADCSEQ_MODE_HI:`ADCSEQ_MODE_LO])
            `ADCSEQ_MODE_CONT: power_aux = c[`ADCSEQ_CSEL_HI];
            `ADCSEQ_MODE_SNAP: power_aux = (c[`ADCSEQ_SSEL_HI:`ADCSEQ_SSEL_LO] ==
                                            `ADCSEQ_SSEL_AUX12);
            default:           power_aux = 1'b0;
         endcase
      end
   endfunction

   // ------------------------------------------------------------------
   // control register and restart strobe
   // ------------------------------------------------------------------
   reg  [7:0] ctrl;
   reg        restart;
   reg  [1:0] v_st;
   reg  [2:0] v_chan;
   reg  [1:0] i_st;
   reg        i_cal;
   reg        pwr_upd;

   wire [1:0] mode     = ctrl[`ADCSEQ_MODE_HI:`ADCSEQ_MODE_LO];
   wire       cont     = (mode == `ADCSEQ_MODE_CONT);
   wire       shut     = (mode == `ADCSEQ_MODE_SHUT);
   wire       cal_dmnd = ctrl[`ADCSEQ_CAL_BIT];
   wire [5:0] mask     = chan_mask(ctrl);
   wire [3:0] v_first  = first_chan(mask, 3'h0);
   wire [3:0] v_next   = first_chan(mask, v_chan + 3'h1);

   // a write loads the register and restarts both sequencers next cycle;
   // reset also issues a restart so the default scan begins on its own
   always @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         ctrl    <= `ADCSEQ_CTRL_RESET;
         restart <= 1'b1;
      end else begin
         restart <= CTRL_WR_I;
         if (CTRL_WR_I) begin
            ctrl <= CTRL_DATA_I;
         end
      end
   end

   // ------------------------------------------------------------------
   // voltage converter sequence
   // ------------------------------------------------------------------

   // walk the mask: wrap in continuous scan, halt after last otherwise
   always @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         v_st   <= ST_IDLE;
         v_chan <= 3'h0;
      end else if (restart) begin
         // abandon whatever was running and begin the new list
         v_chan <= v_first[2:0];
         if (!shut && v_first[3]) begin
            v_st <= ST_START;
         end else begin
            v_st <= ST_IDLE;
         end
      end else begin
         case (v_st)
            ST_START: begin
               v_st <= ST_WAIT;
            end
            ST_WAIT: begin
               if (VCONV_DONE_I) begin
                  if (v_next[3]) begin
                     v_chan <= v_next[2:0];
                     v_st   <= ST_START;
                  end else if (cont) begin
                     v_chan <= v_first[2:0];
                     v_st   <= ST_START;
                  end else begin
                     v_st <= ST_IDLE;
                  end
               end
            end
            default: begin
               v_st <= ST_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // current converter sequence
   // ------------------------------------------------------------------

   // each pass is an optional calibration then one conversion; both
   // current converters share the same start and finish together
   always @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         i_st    <= ST_IDLE;
         i_cal   <= 1'b0;
         pwr_upd <= 1'b0;
      end else begin
         pwr_upd <= 1'b0;
         if (restart) begin
            // on demand or every time, a write is followed by a calibration unless it selects shutdown
            i_cal <= 1'b1;
            if (shut) begin
               i_st <= ST_IDLE;
            end else begin
               i_st <= ST_START;
            end
         end else begin
            case (i_st)
               ST_START: begin
                  i_st <= ST_WAIT;
               end
               ST_WAIT: begin
                  if (ICONV_DONE_I) begin
                     if (i_cal) begin
                        i_cal <= 1'b0;
                        i_st  <= ST_START;
                     end else begin
                        pwr_upd <= power_en(ctrl);
                        if (cont) begin
                           i_cal <= ~cal_dmnd;
                           i_st  <= ST_START;
                        end else begin
                           i_st <= ST_IDLE;
                        end
                     end
                  end
               end
               default: begin
                  i_st <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign CTRL_O        = ctrl;
   assign VCONV_START_O = (v_st == ST_START);
   assign VCONV_CHAN_O  = v_chan;
   assign VCONV_BUSY_O  = (v_st != ST_IDLE);
   assign ICONV_START_O = (i_st == ST_START);
   assign ICONV_CAL_O   = i_cal;
   assign ICONV_BUSY_O  = (i_st != ST_IDLE);
   assign POWER_UPD_O   = pwr_upd;
   assign POWER_AUX_O   = power_aux(ctrl);
   assign SHUTDOWN_O    = shut;

endmodule // adcseq_sequencer

/* File: test/adc_conversion_sequencer_tb.sv */
// adc_conversion_sequencer_tb.sv: self-checking bench for the conversion sequencer.
// assumes: converter model on the far side; 250 MHz clock; checker bound separately.
module adc_conversion_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(g, e, m) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
   $display("CHECK FAILED at %0t: %s", $time, m); end end
   typedef struct { logic [7:0] d; int nv; logic [17:0] seq; int npw; } adcseq_row_t;
   logic MCLK_I = 0, SYS_RST_I = 1, CTRL_WR_I = 0;
   logic [7:0] CTRL_DATA_I = 8'h00, vlat = 8'h04, ilat = 8'h09, CTRL_O;
   logic [2:0] VCONV_CHAN_O;
   logic VCONV_START_O, VCONV_BUSY_O, ICONV_START_O, ICONV_CAL_O, ICONV_BUSY_O;
   logic POWER_UPD_O, POWER_AUX_O, SHUTDOWN_O, vdone, idone;
   int n_fail = 0, samples_checked = 0, nv, ni, ncal, npw;
   logic [17:0] seq;
   adcseq_row_t rows [0:14] = '{'{8'h00, 6, 18'o012345, 0}, '{8'h08, 6, 18'o010101, 0},
      '{8'h10, 6, 18'o232323, 0}, '{8'h18, 6, 18'o234523, 0}, '{8'h88, 6, 18'o010101, 0},
      '{8'h20, 1, 18'o0, 0}, '{8'h21, 1, 18'o1, 0}, '{8'h22, 1, 18'o2, 0},
      '{8'h23, 1, 18'o3, 0}, '{8'h24, 1, 18'o4, 0}, '{8'h25, 1, 18'o5, 0},
      '{8'h26, 2, 18'o01, 1}, '{8'h27, 2, 18'o23, 1}, '{8'h40, 6, 18'o012345, 1},
      '{8'ha7, 2, 18'o23, 1}};
   always #2 MCLK_I = ~MCLK_I;
   adcseq_sequencer u_adcseq_sequencer (.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I),
      .CTRL_WR_I(CTRL_WR_I), .CTRL_DATA_I(CTRL_DATA_I), .VCONV_DONE_I(vdone),
      .ICONV_DONE_I(idone), .CTRL_O(CTRL_O), .VCONV_START_O(VCONV_START_O),
      .VCONV_CHAN_O(VCONV_CHAN_O), .VCONV_BUSY_O(VCONV_BUSY_O),
      .ICONV_START_O(ICONV_START_O), .ICONV_CAL_O(ICONV_CAL_O), .ICONV_BUSY_O(ICONV_BUSY_O),
      .POWER_UPD_O(POWER_UPD_O), .POWER_AUX_O(POWER_AUX_O), .SHUTDOWN_O(SHUTDOWN_O));
   adcseq_conv_model u_adcseq_conv_model (.clk_i(MCLK_I), .rst_i(SYS_RST_I),
      .vstart_i(VCONV_START_O), .istart_i(ICONV_START_O), .vlat_i(vlat), .ilat_i(ilat),
      .vdone_o(vdone), .idone_o(idone));
   // count starts, calibrations, power updates and the first six channels
   always @(posedge MCLK_I) begin
      if (VCONV_START_O === 1'b1) begin
         nv++;
         if (nv <= 6) seq = {seq[14:0], VCONV_CHAN_O};
      end
      ni += (ICONV_START_O === 1'b1);
      ncal += (ICONV_START_O === 1'b1 && ICONV_CAL_O === 1'b1);
      npw += (POWER_UPD_O === 1'b1);
   end
   task clr; {nv, ni, ncal, npw, seq} = '0; endtask
   // one control write; counters cleared after the restart edge, so starts
   // launched by the abandoned run just before the restart are not counted
   task wr(input logic [7:0] d);
      @(posedge MCLK_I) {CTRL_WR_I, CTRL_DATA_I} <= {1'b1, d};
      @(posedge MCLK_I) CTRL_WR_I <= 1'b0;
      @(posedge MCLK_I);
      #1 clr;
   endtask
   task run(input logic [7:0] d, input int nv_e, input logic [17:0] seq_e, input int npw_e,
            input bit dowr);
      if (dowr) wr(d);
      repeat (300) @(posedge MCLK_I);
      #1 `CHK(CTRL_O, d, "readback")
      `CHK(seq, seq_e, "channel order")
      `CHK(POWER_AUX_O, (d[6:5] == 2'h0) ? d[4] : (d[6:5] == 2'h1 && d[2:0] == 3'h7),
           "power operand")
      if (d[6:5] == 2'h0) begin
         `CHK(nv >= 6 && npw > 0, 1'b1, "scan stalled")
         `CHK(ni > 2 && (d[7] ? ncal == 1 : (2*ncal-ni == 0 || 2*ncal-ni == 1)), 1'b1,
              "calibration policy")
      end else begin
         `CHK(nv == nv_e && ni == 2 && ncal == 1, 1'b1, "conversion count")
         `CHK(npw, npw_e, "power updates")
         `CHK(VCONV_BUSY_O | ICONV_BUSY_O, 1'b0, "not halted")
      end
      $display("test %h done", d);
   endtask
   task rst;
      @(posedge MCLK_I) SYS_RST_I <= 1'b1;
      repeat (10) @(posedge MCLK_I);
      `CHK({CTRL_O, VCONV_BUSY_O, ICONV_BUSY_O}, 10'h000, "reset state")
      clr;
      @(posedge MCLK_I) SYS_RST_I <= 1'b0;
   endtask
   task end_of_test;
      $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rst;
      run(8'h00, 6, 18'o012345, 0, 0);
      foreach (rows[i]) run(rows[i].d, rows[i].nv, rows[i].seq, rows[i].npw, 1);
      vlat = 8'h01;
      ilat = 8'h01;
      @(posedge MCLK_I) {CTRL_WR_I, CTRL_DATA_I} <= {1'b1, 8'h27};
      @(posedge MCLK_I) CTRL_DATA_I <= 8'h20;
      @(posedge MCLK_I) CTRL_WR_I <= 1'b0;
      @(posedge MCLK_I);
      #1 clr;
      run(8'h20, 1, 18'o0, 0, 0);
      vlat = 8'h1e;
      ilat = 8'h28;
      wr(8'h60);
      repeat (100) @(posedge MCLK_I);
      `CHK({nv, ni, SHUTDOWN_O, CTRL_O}, {32'd0, 32'd0, 1'b1, 8'h60}, "shutdown")
      $display("test shutdown done");
      run(8'h00, 6, 18'o012345, 0, 1);
      rst;
      run(8'h00, 6, 18'o012345, 0, 0);
      end_of_test;
   end
   // watchdog against a hung sequence
   initial begin
      #200000;
      n_fail++;
      end_of_test;
   end
endmodule // adc_conversion_sequencer_tb

/* File: test/adcseq_conv_model.sv */
// adcseq_conv_model.sv: behavioural converters that answer each start with a done pulse.
// assumes: starts are one-cycle pulses; latencies from the bench are at least 1.
module adcseq_conv_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       vstart_i,
   input  wire logic       istart_i,
   input  wire logic [7:0] vlat_i,
   input  wire logic [7:0] ilat_i,
   output logic            vdone_o,
   output logic            idone_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] vcnt;
   logic [7:0] icnt;
   // count down from each start, pulse done when the count runs out
   always @(posedge clk_i) begin
      vcnt <= rst_i ? 8'h00 : vstart_i ? vlat_i : (vcnt != 8'h00) ? vcnt - 8'h01 : 8'h00;
      icnt <= rst_i ? 8'h00 : istart_i ? ilat_i : (icnt != 8'h00) ? icnt - 8'h01 : 8'h00;
      vdone_o <= !rst_i && vcnt == 8'h01;
      idone_o <= !rst_i && icnt == 8'h01;
   end
endmodule // adcseq_conv_model

/* File: test/adcseq_sequencer_chk.sv */
// adcseq_sequencer_chk.sv: port assertions for the conversion sequencer.
// assumes: bound to adcseq_sequencer; one clock, synchronous active-high reset.
module adcseq_chk (
   input wire logic       MCLK_I,
   input wire logic       SYS_RST_I,
   input wire logic       CTRL_WR_I,
   input wire logic [7:0] CTRL_DATA_I,
   input wire logic [7:0] CTRL_O,
   input wire logic       VCONV_START_O,
   input wire logic [2:0] VCONV_CHAN_O,
   input wire logic       VCONV_BUSY_O,
   input wire logic       ICONV_START_O,
   input wire logic       ICONV_CAL_O,
   input wire logic       ICONV_BUSY_O,
   input wire logic       POWER_UPD_O,
   input wire logic       POWER_AUX_O,
   input wire logic       SHUTDOWN_O
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (SYS_RST_I);
   // channels allowed by the continuous scan selection
   wire [5:0] cmask = (CTRL_O[4:3] == 2'h0) ? 6'h3f : (CTRL_O[4:3] == 2'h1) ? 6'h03 :
                      (CTRL_O[4:3] == 2'h2) ? 6'h0c : 6'h3c;
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   property p_wr_ctrl; CTRL_WR_I |=> CTRL_O == $past(CTRL_DATA_I); endproperty
   a_wr_ctrl: assert property (p_wr_ctrl)
      else $error("control readback wrong");
   property p_restart;
      CTRL_WR_I && CTRL_DATA_I[6:5] != 2'h3 ##1 !CTRL_WR_I
         |=> VCONV_START_O && ICONV_START_O && ICONV_CAL_O;
   endproperty
   a_restart: assert property (p_restart)
      else $error("no calibrated restart after write");
   property p_snap_chan;
      CTRL_WR_I && CTRL_DATA_I[6:5] == 2'h1 && CTRL_DATA_I[2:1] != 2'h3 ##1 !CTRL_WR_I
         |=> VCONV_CHAN_O == CTRL_O[2:0];
   endproperty
   a_snap_chan: assert property (p_snap_chan)
      else $error("snapshot channel wrong");
   property p_pair_chan;
      CTRL_WR_I && CTRL_DATA_I[6:5] == 2'h1 && CTRL_DATA_I[2:1] == 2'h3 ##1 !CTRL_WR_I
         |=> VCONV_CHAN_O == {1'b0, CTRL_O[0], 1'b0};
   endproperty
   a_pair_chan: assert property (p_pair_chan)
      else $error("pair snapshot first channel wrong");
   property p_cont_mask;
      VCONV_START_O && CTRL_O[6:5] == 2'h0 |-> cmask[VCONV_CHAN_O];
   endproperty
   a_cont_mask: assert property (p_cont_mask)
      else $error("scan channel outside selection");
   property p_shut;
      CTRL_WR_I && CTRL_DATA_I[6:5] == 2'h3 ##1 !CTRL_WR_I [*3] |-> SHUTDOWN_O &&
         !VCONV_START_O && !ICONV_START_O && !VCONV_BUSY_O && !ICONV_BUSY_O;
   endproperty
   a_shut: assert property (p_shut)
      else $error("converters active in shutdown");
   property p_aux;
      !CTRL_O[6] |-> POWER_AUX_O == (CTRL_O[5] ? CTRL_O[2:0] == 3'h7 : CTRL_O[4]);
   endproperty
   a_aux: assert property (p_aux)
      else $error("power operand choice wrong");
   property p_nopwr;
      CTRL_O[6:5] == 2'h1 && CTRL_O[2:1] != 2'h3 && !$past(CTRL_WR_I) &&
         !$past(CTRL_WR_I, 2) |-> !POWER_UPD_O;
   endproperty
   a_nopwr: assert property (p_nopwr)
      else $error("power updated by single snapshot");
   property p_rst;
      $fell(SYS_RST_I) && !CTRL_WR_I |-> CTRL_O == 8'h00 ##1
         VCONV_START_O && ICONV_START_O && ICONV_CAL_O && VCONV_CHAN_O == 3'h0;
   endproperty
   a_rst: assert property (p_rst)
      else $error("reset start wrong");
   // main scenarios
   c_pair: cover property (CTRL_WR_I && CTRL_DATA_I == 8'h27);
   c_shut: cover property (SHUTDOWN_O ##1 CTRL_WR_I);
   c_auxpw: cover property (POWER_UPD_O && POWER_AUX_O);
endmodule // adcseq_chk

bind adcseq_sequencer adcseq_chk u_adcseq_chk (.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I),
   .CTRL_WR_I(CTRL_WR_I), .CTRL_DATA_I(CTRL_DATA_I), .CTRL_O(CTRL_O),
   .VCONV_START_O(VCONV_START_O), .VCONV_CHAN_O(VCONV_CHAN_O), .VCONV_BUSY_O(VCONV_BUSY_O),
   .ICONV_START_O(ICONV_START_O), .ICONV_CAL_O(ICONV_CAL_O), .ICONV_BUSY_O(ICONV_BUSY_O),
   .POWER_UPD_O(POWER_UPD_O), .POWER_AUX_O(POWER_AUX_O), .SHUTDOWN_O(SHUTDOWN_O));
